/* File: shared/abse_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ABSE_DEFS_SVH
`define ABSE_DEFS_SVH
`define ABSE_ADDR_SHIFT 16'hff1f
`define ABSE_ADDR_MODE 16'hff60
`define ABSE_ADDR_CTRL 16'hff61
`define ABSE_ADDR_OWN 16'hff62
`define ABSE_ADDR_IRQT 16'hff63
`define ABSE_MODE_ENABLE 7
`define ABSE_MODE_MATCH 6
`define ABSE_MODE_WAKE 5
`define ABSE_MODE_CLKSEL 1
`define ABSE_IRQT_CLD 6
`define ABSE_IRQT_SIC 5
`define ABSE_IRQT_SVAM 4
`define ABSE_RST_BYTE 8'h00
`define ABSE_CLK_MHZ 50
`define ABSE_SCK_HALF_NS 2000
`define ABSE_SCK_HALF_CYC ((`ABSE_SCK_HALF_NS * `ABSE_CLK_MHZ) / 1000)
`define ABSE_BYTE_BITS 4'h8
`define ABSE_IRQ_EDGE 4'h9
`endif

/* File: shared/abse_pkg.sv */
// types shared by the addressed serial bus engine
package abse_pkg;
	typedef enum logic [1:0] {
		ABSE_IDLE = 2'b00,
		ABSE_WAIT = 2'b01,
		ABSE_SHIFT = 2'b10,
		ABSE_TAIL = 2'b11
	} abse_phase_e;
	typedef struct packed {
		logic sck;
		logic sda;
	} abse_pins_s;
	typedef struct packed {
		logic sync_busy_enable;
		logic ack_detected;
		logic auto_ack_enable;
		logic manual_ack_trigger;
		logic command_marker_seen;
		logic free_marker_seen;
		logic send_command_marker;
		logic send_free_marker;
	} abse_ctrl_s;
endpackage : abse_pkg

/* File: src/abse_sync.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module abse_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	// first stage feeds only the second; idle bus levels are high
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_reg <= '1;
			q <= '1;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : abse_sync
`default_nettype wire

/* File: src/abse_cmp.sv */
// registered comparator of shift data against own address
`timescale 1ns/1ps
`default_nettype none
module abse_cmp #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// operands and result
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	output logic eq
);
	// one cycle late; the shift data settles long before it is used
	always_ff @(posedge clk)
	begin
		if (rst)
			eq <= 1'b0;
		else
			eq <= (a == b);
	end
endmodule : abse_cmp
`default_nettype wire

/* File: src/abse_engine.sv */
// addressed serial bus engine: markers, shifter, ack, busy, wakeup
// Operation
// - ack_detected sets when data line is low at a serial clock rise after a byte
// - ack_detected clears at first fall after start, on disable, on reset
// - busy enable set: drive busy low from the fall after the acknowledge
// - busy enable cleared: busy ends at the next serial clock fall
// - a new transfer start clears busy but keeps the busy enable bit
// - clock level status reads the clock, and 0 while the channel is off
// - reset clears the interrupt timing register
// - cause select set while waking: no address wakeup, interrupt on bus free marker
// - master makes free marker as rising data with clock high; sets/clears flags
// - master makes command marker as falling data with clock high; sets flag
// - receiver acknowledges low for one clock, auto or manual; flag sets
// - slave leaves line high as ready before and after transfers
// - master supplies clock; eight data clocks, then acknowledge and busy
// - byte after both markers is address, after command only a command
// - shift write while enabled starts transfer, waiting for ready level
// - irq flag at 9th rise, or on own address match when waking
// - data line only pulled low or released, read through an input
// - wake on address keeps the latch path of the data line released
// - shifter captures the real line level while transmitting
// - match flag follows the comparator of shifter and own address, and 0 while the channel is off
// - data out advances on falls, msb first through the output latch
// - receive data sampled into the shifter on serial clock rises
// - auto ack enabled before completion: ack at the 10th falling edge
// - marker send bits self-clear after the latch moves, and on disable
// - address wakeup only for a byte after both markers were seen
`timescale 1ns/1ps
`include "abse_defs.svh"
`default_nettype none
module abse_engine #(
	parameter int SCK_HALF = `ABSE_SCK_HALF_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// serial clock line
	input wire logic serial_clock_line_in,
	output logic serial_clock_line_out,
	output logic serial_clock_line_oe_n,
	// data line, open drain
	input wire logic data_line_a_in,
	output logic data_line_a_out,
	output logic data_line_a_oe_n,
	// transfer interrupt
	input wire logic irq_flag_clr,
	output logic transfer_irq,
	output logic transfer_irq_flag
);
	import abse_pkg::*;

	abse_pins_s pin_raw;
	abse_pins_s pin_s;
	abse_phase_e phase_reg;
	abse_ctrl_s ctrl_reg;
	logic enable_reg, wake_reg, clksel_reg, sic_reg, svam_reg;
	logic [7:0] shift_reg, own_reg;
	logic match;
	logic [3:0] cnt_reg;
	logic sck_prev_reg, sda_prev_reg, latch_reg, done_reg;
	logic ack_out_reg, ack_given_reg, busy_out_reg, ack_clr_pend_reg;
	logic sck_int_reg, mclk_on_reg;
	logic [15:0] div_reg;

	// pins cross into the clk domain before anything looks at them
	assign pin_raw = '{sck: serial_clock_line_in, sda: data_line_a_in};
	abse_sync #(.W(2)) u_sync (
		.clk(clk),
		.rst(rst),
		.d(pin_raw),
		.q(pin_s)
	);
	abse_cmp #(.W(8)) u_cmp (
		.clk(clk),
		.rst(rst),
		.a(shift_reg),
		.b(own_reg),
		.eq(match)
	);

	// decode and edge finding
	logic wr_mode, wr_ctrl, wr_own, wr_irqt, wr_shift, start_wr;
	logic sck_now, sda_now, sck_rise, sck_fall, free_mark, cmd_mark;
	logic clock_level_status, ack_fire, irq_hit, addr_phase, to_shift;
	assign wr_mode = reg_wr && (reg_addr == `ABSE_ADDR_MODE);
	assign wr_ctrl = reg_wr && (reg_addr == `ABSE_ADDR_CTRL);
	assign wr_own = reg_wr && (reg_addr == `ABSE_ADDR_OWN);
	assign wr_irqt = reg_wr && (reg_addr == `ABSE_ADDR_IRQT);
	assign wr_shift = reg_wr && (reg_addr == `ABSE_ADDR_SHIFT);
	assign start_wr = wr_shift && enable_reg;
	// a master follows its own clock so it never waits on the pin delay
	assign sck_now = clksel_reg ? sck_int_reg : pin_s.sck;
	assign sda_now = pin_s.sda;
	assign sck_rise = sck_now && !sck_prev_reg;
	assign sck_fall = !sck_now && sck_prev_reg;
	// data edges with clock held high are markers, never data
	assign free_mark = enable_reg && sck_now && sck_prev_reg
		&& sda_now && !sda_prev_reg;
	assign cmd_mark = enable_reg && sck_now && sck_prev_reg
		&& !sda_now && sda_prev_reg;
	assign clock_level_status = enable_reg && sck_now;
	assign to_shift = (phase_reg == ABSE_WAIT) && sck_now && sda_now;
	assign addr_phase = ctrl_reg.free_marker_seen
		&& ctrl_reg.command_marker_seen;
	assign ack_fire = ctrl_reg.manual_ack_trigger
		|| (ctrl_reg.auto_ack_enable && done_reg && !ack_given_reg
		&& (cnt_reg >= `ABSE_IRQ_EDGE));
	// byte ends at the rise that makes the count nine
	always_comb
	begin
		irq_hit = 1'b0;
		if (sck_rise && (phase_reg == ABSE_TAIL)
			&& (cnt_reg == `ABSE_BYTE_BITS))
		begin
			if (!wake_reg)
				irq_hit = 1'b1;
			else if (!sic_reg)
				irq_hit = addr_phase && match;
		end
		if (wake_reg && sic_reg && free_mark)
			irq_hit = 1'b1;
	end

	// edge history
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sck_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			sck_prev_reg <= sck_now;
			sda_prev_reg <= sda_now;
		end
	end

	// mode, own address and interrupt timing registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			enable_reg <= 1'b0;
			wake_reg <= 1'b0;
			clksel_reg <= 1'b0;
			own_reg <= `ABSE_RST_BYTE;
			sic_reg <= 1'b0;
			svam_reg <= 1'b0;
		end
		else
		begin
			if (wr_mode)
			begin
				enable_reg <= reg_wdata[`ABSE_MODE_ENABLE];
				wake_reg <= reg_wdata[`ABSE_MODE_WAKE];
				clksel_reg <= reg_wdata[`ABSE_MODE_CLKSEL];
			end
			if (wr_own)
				own_reg <= reg_wdata;
			// low four bits are expected zero and are not stored
			if (wr_irqt)
			begin
				sic_reg <= reg_wdata[`ABSE_IRQT_SIC];
				svam_reg <= reg_wdata[`ABSE_IRQT_SVAM];
			end
		end
	end

	// transfer phase and clock count
	always_ff @(posedge clk)
	begin
		if (rst || !enable_reg)
		begin
			phase_reg <= ABSE_IDLE;
			cnt_reg <= 4'h0;
		end
		else if (start_wr)
			phase_reg <= ABSE_WAIT;
		else
		begin
			unique case (phase_reg)
				ABSE_IDLE: phase_reg <= ABSE_IDLE;
				ABSE_WAIT:
				begin
					// busy slave holds the line low; wait for ready
					if (to_shift)
					begin
						phase_reg <= ABSE_SHIFT;
						cnt_reg <= 4'h0;
					end
				end
				ABSE_SHIFT:
				begin
					if (sck_rise)
						cnt_reg <= cnt_reg + 4'h1;
					if (sck_fall && (cnt_reg == `ABSE_BYTE_BITS))
						phase_reg <= ABSE_TAIL;
				end
				ABSE_TAIL:
				begin
					if (sck_rise && (cnt_reg != 4'hf))
						cnt_reg <= cnt_reg + 4'h1;
				end
			endcase
		end
	end

	// shifter: sample on rises, load from the register port
	always_ff @(posedge clk)
	begin
		if (rst)
			shift_reg <= `ABSE_RST_BYTE;
		else if (wr_shift)
			shift_reg <= reg_wdata;
		else if (sck_rise && (phase_reg == ABSE_SHIFT))
			shift_reg <= {shift_reg[6:0], sda_now};
	end

	// output latch: msb first, markers move it, high once a byte ends
	always_ff @(posedge clk)
	begin
		if (rst)
			latch_reg <= 1'b0;
		else if (ctrl_reg.send_free_marker)
			latch_reg <= 1'b1;
		else if (ctrl_reg.send_command_marker)
			latch_reg <= 1'b0;
		else if (to_shift)
			latch_reg <= shift_reg[7];
		else if (sck_fall && (phase_reg == ABSE_SHIFT))
			latch_reg <= (cnt_reg == `ABSE_BYTE_BITS)
				? 1'b1 : shift_reg[7];
	end

	// byte completion, acknowledge and busy drive
	always_ff @(posedge clk)
	begin
		if (rst || !enable_reg)
		begin
			done_reg <= 1'b0;
			ack_out_reg <= 1'b0;
			ack_given_reg <= 1'b0;
			busy_out_reg <= 1'b0;
		end
		else if (start_wr)
		begin
			done_reg <= 1'b0;
			ack_given_reg <= 1'b0;
			ack_out_reg <= 1'b0;
			busy_out_reg <= 1'b0;
		end
		else
		begin
			if (sck_rise && (phase_reg == ABSE_SHIFT)
				&& (cnt_reg == 4'h7))
				done_reg <= 1'b1;
			if (sck_fall)
			begin
				ack_out_reg <= ack_fire;
				if (ack_fire)
					ack_given_reg <= 1'b1;
				if (!ctrl_reg.sync_busy_enable)
					busy_out_reg <= 1'b0;
				else if (ack_out_reg)
					busy_out_reg <= 1'b1;
			end
		end
	end

	// control register: detect flags, self-clearing triggers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_reg <= '0;
			ack_clr_pend_reg <= 1'b0;
		end
		else if (!enable_reg)
		begin
			// the two enables survive a disable; flags and triggers drop
			ctrl_reg.ack_detected <= 1'b0;
			ctrl_reg.manual_ack_trigger <= 1'b0;
			ctrl_reg.command_marker_seen <= 1'b0;
			ctrl_reg.free_marker_seen <= 1'b0;
			ctrl_reg.send_command_marker <= 1'b0;
			ctrl_reg.send_free_marker <= 1'b0;
			ack_clr_pend_reg <= 1'b0;
			if (wr_ctrl)
			begin
				ctrl_reg.sync_busy_enable <= reg_wdata[7];
				ctrl_reg.auto_ack_enable <= reg_wdata[5];
			end
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_reg.sync_busy_enable <= reg_wdata[7];
				ctrl_reg.auto_ack_enable <= reg_wdata[5];
			end
			// marker triggers act one cycle after the write, then drop
			ctrl_reg.send_free_marker <= wr_ctrl && reg_wdata[0];
			ctrl_reg.send_command_marker <= wr_ctrl && reg_wdata[1];
			if (wr_ctrl && reg_wdata[4])
				ctrl_reg.manual_ack_trigger <= 1'b1;
			else if (start_wr || (sck_fall && ack_fire))
				ctrl_reg.manual_ack_trigger <= 1'b0;
			// ack flag clears at the first fall once shifting starts
			if (start_wr)
				ack_clr_pend_reg <= 1'b1;
			else if (sck_fall && (phase_reg == ABSE_SHIFT))
				ack_clr_pend_reg <= 1'b0;
			if (sck_rise && done_reg && !sda_now)
				ctrl_reg.ack_detected <= 1'b1;
			else if (sck_fall && ack_clr_pend_reg
				&& (phase_reg == ABSE_SHIFT))
				ctrl_reg.ack_detected <= 1'b0;
			// marker flags: detection wins over the start clear
			if (free_mark)
				ctrl_reg.free_marker_seen <= 1'b1;
			else if (start_wr || (irq_hit == 1'b0 && wake_reg && !sic_reg
				&& sck_rise && addr_phase && (phase_reg == ABSE_TAIL)
				&& (cnt_reg == `ABSE_BYTE_BITS)))
				ctrl_reg.free_marker_seen <= 1'b0;
			if (cmd_mark)
				ctrl_reg.command_marker_seen <= 1'b1;
			else if (free_mark || start_wr)
				ctrl_reg.command_marker_seen <= 1'b0;
		end
	end

	// interrupt pulse and flag; a new event beats the clear
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			transfer_irq <= 1'b0;
			transfer_irq_flag <= 1'b0;
		end
		else
		begin
			transfer_irq <= irq_hit && enable_reg;
			if (irq_hit && enable_reg)
				transfer_irq_flag <= 1'b1;
			else if (irq_flag_clr)
				transfer_irq_flag <= 1'b0;
		end
	end

	// master clock: runs from shift start until the line reads ready
	always_ff @(posedge clk)
	begin
		if (rst || !enable_reg || !clksel_reg)
		begin
			mclk_on_reg <= 1'b0;
			sck_int_reg <= 1'b1;
			div_reg <= 16'h0;
		end
		else
		begin
			if (to_shift)
				mclk_on_reg <= 1'b1;
			else if (sck_rise && (cnt_reg >= `ABSE_IRQ_EDGE) && sda_now)
				mclk_on_reg <= 1'b0;
			if (!mclk_on_reg)
			begin
				div_reg <= 16'h0;
				sck_int_reg <= 1'b1;
			end
			else if (div_reg == 16'(SCK_HALF - 1))
			begin
				div_reg <= 16'h0;
				sck_int_reg <= !sck_int_reg;
			end
			else
				div_reg <= div_reg + 16'h1;
		end
	end

	// pins: data only pulled low or released, never driven high
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			data_line_a_out <= 1'b0;
			data_line_a_oe_n <= 1'b1;
			serial_clock_line_out <= 1'b1;
			serial_clock_line_oe_n <= 1'b1;
		end
		else
		begin
			data_line_a_out <= 1'b0;
			data_line_a_oe_n <= !(enable_reg && ((!latch_reg && !wake_reg)
				|| ack_out_reg || busy_out_reg));
			serial_clock_line_out <= sck_int_reg;
			serial_clock_line_oe_n <= !(enable_reg && clksel_reg);
		end
	end

	// read port; trigger bits always read zero
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				`ABSE_ADDR_MODE: reg_rdata <= {enable_reg,
					enable_reg && match, wake_reg, 3'b000,
					clksel_reg, 1'b0};
				`ABSE_ADDR_CTRL: reg_rdata <= {ctrl_reg[7:5], 1'b0,
					ctrl_reg[3:2], 2'b00};
				`ABSE_ADDR_OWN: reg_rdata <= own_reg;
				`ABSE_ADDR_IRQT: reg_rdata <= {1'b0, clock_level_status, sic_reg,
					svam_reg, 4'h0};
				`ABSE_ADDR_SHIFT: reg_rdata <= shift_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	clock_level_read_a: assert property (reg_rd && !enable_reg
		&& reg_addr == `ABSE_ADDR_IRQT |=> reg_rdata[6] == 1'b0)
		else $error("clock level status not zero while off");
	ack_detect_set_a: assert property (enable_reg && sck_rise
		&& done_reg && !sda_now && !start_wr |=> ctrl_reg.ack_detected)
		else $error("acknowledge not detected");
	ack_off_clear_a: assert property (!enable_reg
		|=> !ctrl_reg.ack_detected)
		else $error("ack flag survives disable");
	busy_after_ack_a: assert property (enable_reg && sck_fall
		&& ack_out_reg && ctrl_reg.sync_busy_enable && !start_wr
		|=> busy_out_reg ##1 !data_line_a_oe_n)
		else $error("busy not driven after acknowledge");
	busy_end_fall_a: assert property (sck_fall
		&& !ctrl_reg.sync_busy_enable |=> !busy_out_reg)
		else $error("busy not ended at fall");
	start_clear_busy_a: assert property (start_wr && !wr_ctrl
		|=> !busy_out_reg && $stable(ctrl_reg.sync_busy_enable))
		else $error("start did not clear busy");
	wake_release_a: assert property (wake_reg && !ack_out_reg
		&& !busy_out_reg |=> data_line_a_oe_n)
		else $error("data line pulled while waking");
	free_marker_a: assert property (free_mark
		|=> ctrl_reg.free_marker_seen && !ctrl_reg.command_marker_seen)
		else $error("free marker flags wrong");
	irq_ninth_a: assert property (enable_reg && !wake_reg
		&& !start_wr && phase_reg == ABSE_TAIL && sck_rise
		&& cnt_reg == `ABSE_BYTE_BITS |=> transfer_irq ##1 !transfer_irq)
		else $error("irq missing at ninth rise");
	msb_first_a: assert property (enable_reg && !start_wr
		&& sck_fall && phase_reg == ABSE_SHIFT && cnt_reg < 4'h8
		&& !ctrl_reg.send_free_marker && !ctrl_reg.send_command_marker
		|=> latch_reg == $past(shift_reg[7]))
		else $error("latch not loaded from shifter msb");
	sample_rise_a: assert property (enable_reg && !wr_shift
		&& sck_rise && phase_reg == ABSE_SHIFT
		|=> shift_reg[0] == $past(sda_now))
		else $error("line not sampled on rise");

	byte_done_c: cover property (phase_reg == ABSE_SHIFT
		##1 phase_reg == ABSE_TAIL);
	addr_wake_c: cover property (wake_reg && irq_hit && !sic_reg);
	busy_wait_c: cover property (phase_reg == ABSE_WAIT && !sda_now
		##1 phase_reg == ABSE_WAIT ##[1:1000] to_shift);
endmodule : abse_engine
`default_nettype wire

/* File: verif/abse_master_model.sv */
// far-side bus master model: drives the clock, pulls data low
`timescale 1ns/1ps
`default_nettype none
module abse_master_model (
	// wire level of the data line
	input wire logic data_w,
	// clock and data pull
	output logic sck,
	output logic sda_pull,
	// low seen on the line where this side released it
	output logic saw_low
);
	int half_ns;
	// clock stands high between frames, data released
	initial
	begin
		sck = 1'b1;
		sda_pull = 1'b0;
		saw_low = 1'b0;
		half_ns = 80;
	end
	// flag reset between frames
	task automatic clr_flag;
		saw_low = 1'b0;
	endtask : clr_flag
	// marker: data moves only while the clock stands high
	task automatic mark(input logic low);
		sda_pull = low;
		#(half_ns);
	endtask : mark
	// one clock; data changes only while the clock is low
	task automatic clk_bit(input logic pull, output logic lvl);
		sck = 1'b0;
		#(half_ns / 2);
		sda_pull = pull;
		#(half_ns / 2);
		sck = 1'b1;
		#(half_ns - 5);
		lvl = data_w; // sampled late, slave gets the whole phase
		#5;
	endtask : clk_bit
	// eight bits msb first; a released one that reads low is noted
	task automatic send_bits(input logic [7:0] b);
		logic lvl;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(~b[i], lvl);
			if (b[i] && !lvl)
				saw_low = 1'b1;
		end
	endtask : send_bits
endmodule : abse_master_model
`default_nettype wire

/* File: verif/abse_engine_tb_top.sv */
// self-checking bench for the addressed serial bus engine
`timescale 1ns/1ps
`include "abse_defs.svh"
`default_nettype none
module abse_engine_tb_top;
	import abse_pkg::*;
	localparam logic [15:0] a_sh = `ABSE_ADDR_SHIFT;
	localparam logic [15:0] a_md = `ABSE_ADDR_MODE;
	localparam logic [15:0] a_ct = `ABSE_ADDR_CTRL;
	localparam logic [15:0] a_ow = `ABSE_ADDR_OWN;
	localparam logic [15:0] a_it = `ABSE_ADDR_IRQT;
	logic clk;
	logic rst;
	logic [15:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic irq_flag_clr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic sck_out;
	logic sck_oe_n;
	logic sda_out;
	logic sda_oe_n;
	logic irq;
	logic irq_flag;
	logic p_sck;
	logic p_pull;
	logic p_low;
	logic rd_d;
	logic lvl;
	logic [31:0] rng;
	logic [7:0] b;
	logic [7:0] own;
	logic [7:0] bits;
	logic [23:0] exp_q[$];
	int n_fail;
	int samples_checked;
	int irq_n;
	int base;
	wire sck_w;
	wire data_w;
	// clock pin: engine drives it when master, else the far side
	assign sck_w = (sck_oe_n === 1'b0) ? sck_out : p_sck;
	// open drain with pull-up: released reads high
	assign data_w = !(p_pull || (sda_oe_n === 1'b0));
	abse_engine #(.SCK_HALF(4)) i_abse_engine (
		.clk(clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.serial_clock_line_in(sck_w),
		.serial_clock_line_out(sck_out),
		.serial_clock_line_oe_n(sck_oe_n),
		.data_line_a_in(data_w),
		.data_line_a_out(sda_out),
		.data_line_a_oe_n(sda_oe_n),
		.irq_flag_clr(irq_flag_clr),
		.transfer_irq(irq),
		.transfer_irq_flag(irq_flag)
	);
	abse_master_model i_abse_master_model (
		.data_w(data_w),
		.sck(p_sck),
		.sda_pull(p_pull),
		.saw_low(p_low)
	);
	// 50 mhz system clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	// strobes last one cycle with a gap, so no edge sees two writes
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		exp_q.push_back({a, e});
		@(negedge clk);
		reg_rd = 1'b0;
	endtask : rd
	// one clock from the far side with data released, level checked late in high
	task automatic pls(input string nm, input logic [7:0] e);
		i_abse_master_model.clk_bit(1'b0, lvl);
		chk(nm, e, {7'h00, lvl});
	endtask : pls
	// read data lands one cycle after the strobe edge
	always @(posedge clk)
		rd_d <= reg_rd;
	always @(posedge clk)
		if (irq === 1'b1)
			irq_n++;
	// monitor: oldest expected read value against what came back
	always @(negedge clk)
		if (rd_d === 1'b1 && exp_q.size() > 0)
		begin
			logic [23:0] e;
			e = exp_q.pop_front();
			chk($sformatf("reg %h", e[23:8]), e[7:0], reg_rdata);
			chk("data out level", 8'h00, {7'h00, sda_out});
		end
	// watchdog: whole run needs well under 60 us
	initial
	begin
		#200000;
		n_fail++;
		summarize();
	end
	initial
	begin
		rst = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		irq_flag_clr = 1'b0;
		rd_d = 1'b0;
		rng = 32'h00010800;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		rd(a_it, 8'h00);
		rd(a_ct, 8'h00);
		rd(a_md, 8'h00);
		wr(16'hff64, 8'h5a);
		rd(16'hff64, 8'h00);
		wr(a_it, 8'h30);
		rd(a_it, 8'h30);
		wr(a_md, 8'h80);
		repeat (4) @(negedge clk);
		rd(a_it, 8'h70);
		wr(a_it, 8'h00);
		wr(a_ct, 8'h01);
		repeat (6) @(negedge clk);
		rd(a_ct, 8'h04);
		i_abse_master_model.mark(1'b1);
		rd(a_ct, 8'h0c);
		i_abse_master_model.mark(1'b0);
		rd(a_ct, 8'h04);
		// receive: auto ack, manual ack, busy ended two ways
		for (int m = 0; m < 4; m++)
		begin
			rng = xs(rng);
			b = rng[7:0];
			i_abse_master_model.half_ns = 80 + 80 * (m % 2);
			wr(a_ct, (m >= 2) ? 8'ha0 : ((m == 0) ? 8'h20 : 8'h00));
			wr(a_sh, 8'hff);
			base = irq_n;
			i_abse_master_model.clr_flag();
			i_abse_master_model.send_bits(b);
			repeat (10) @(negedge clk);
			chk("irq before 9th", 8'h00, 8'(irq_n - base));
			i_abse_master_model.clk_bit(1'b0, lvl);
			repeat (6) @(negedge clk);
			chk("irq at 9th", 8'h01, 8'(irq_n - base));
			if (m == 1)
				wr(a_ct, 8'h10);
			pls("ack level", 8'h00);
			pls("after ack", (m >= 2) ? 8'h00 : 8'h01);
			chk("released", 8'h00, {7'h00, p_low});
			rd(a_sh, b);
			if (m == 2)
				wr(a_ct, 8'h20);
			if (m == 3)
				wr(a_sh, 8'hff);
			if (m >= 2)
				pls("ready", 8'h01);
			if (m == 3)
				wr(a_md, 8'h00);
			if (m == 3)
				rd(a_ct, 8'ha0);
			else
				rd(a_ct, (m == 1) ? 8'h40 : 8'h60);
		end
		// wake on address: match, mismatch, cause select
		wr(a_md, 8'ha0);
		wr(a_ct, 8'h00);
		rng = xs(rng);
		own = rng[7:0];
		wr(a_ow, own);
		for (int k = 0; k < 3; k++)
		begin
			wr(a_it, (k == 2) ? 8'h20 : 8'h00);
			wr(a_sh, 8'h00);
			base = irq_n;
			i_abse_master_model.clr_flag();
			i_abse_master_model.mark(1'b1);
			i_abse_master_model.mark(1'b0);
			i_abse_master_model.mark(1'b1);
			i_abse_master_model.send_bits((k == 1) ? ~own : own);
			i_abse_master_model.clk_bit(1'b0, lvl);
			i_abse_master_model.clk_bit(1'b0, lvl);
			repeat (6) @(negedge clk);
			chk("wake irq", (k == 1) ? 8'h00 : 8'h01, 8'(irq_n - base));
			chk("wake released", 8'h00, {7'h00, p_low});
		end
		chk("irq flag", 8'h01, {7'h00, irq_flag});
		// random clear strobe first, then a sure one
		rng = xs(rng);
		@(negedge clk);
		irq_flag_clr = rng[0];
		@(negedge clk);
		irq_flag_clr = 1'b0;
		@(negedge clk);
		chk("irq flag rand clear", {7'h00, !rng[0]}, {7'h00, irq_flag});
		@(negedge clk);
		irq_flag_clr = 1'b1;
		@(negedge clk);
		irq_flag_clr = 1'b0;
		@(negedge clk);
		chk("irq flag clear", 8'h00, {7'h00, irq_flag});
		// master transmit with own address equal to the sent byte
		wr(a_it, 8'h00);
		wr(a_md, 8'h82);
		wr(a_ct, 8'h01);
		rng = xs(rng);
		b = rng[7:0];
		wr(a_ow, b);
		wr(a_sh, b);
		repeat (8) @(posedge sck_w) bits = {bits[6:0], data_w};
		repeat (120) @(negedge clk);
		chk("sent bits", b, bits);
		rd(a_sh, b);
		rd(a_md, 8'hc2);
		wr(a_md, 8'h00);
		rd(a_it, 8'h00);
		summarize();
	end
endmodule : abse_engine_tb_top
`default_nettype wire
